// *** common/sops_defines.svh ***
// register offsets, field layout, reset values, select codes and divider periods
`ifndef SOPS_DEFINES_SVH
`define SOPS_DEFINES_SVH

`define SOPS_ADDR_W         8
`define SOPS_OFF_CFG0       8'h00
`define SOPS_REG_STRIDE     8'h04
`define SOPS_OFF_STATUS     8'h0c
`define SOPS_CFG_SEL_MSB    5
`define SOPS_CFG_INV_BIT    6
`define SOPS_RST_CFG0       7'h3f
`define SOPS_RST_CFG1       7'h2e
`define SOPS_RST_CFG2       7'h2f
`define SOPS_RESP_OKAY      2'h0
`define SOPS_RESP_DECERR    2'h3

`define SOPS_SEL_RX_THR     6'h00
`define SOPS_SEL_RX_EOP     6'h01
`define SOPS_SEL_TX_THR     6'h02
`define SOPS_SEL_TX_FULL    6'h03
`define SOPS_SEL_RX_OVF     6'h04
`define SOPS_SEL_TX_UNF     6'h05
`define SOPS_SEL_SYNC       6'h06
`define SOPS_SEL_CRC_PKT    6'h07
`define SOPS_SEL_CCA        6'h09
`define SOPS_SEL_PLL        6'h0a
`define SOPS_SEL_SER_CLK    6'h0b
`define SOPS_SEL_SER_SDATA  6'h0c
`define SOPS_SEL_SER_ADATA  6'h0d
`define SOPS_SEL_CARRIER    6'h0e
`define SOPS_SEL_CRC_MATCH  6'h0f
`define SOPS_SEL_AMP_PD     6'h1b
`define SOPS_SEL_SLEEP_LIM  6'h20
`define SOPS_SEL_HIZ        6'h2e
`define SOPS_SEL_ZERO       6'h2f
`define SOPS_SEL_XO_MIN     6'h30
`define SOPS_SEL_XO_DIV1    6'h30
`define SOPS_SEL_XO_DIV1P5  6'h31
`define SOPS_SEL_XO_DIV2    6'h32
`define SOPS_SEL_XO_DIV3    6'h33
`define SOPS_SEL_XO_DIV4    6'h34
`define SOPS_SEL_XO_DIV6    6'h35
`define SOPS_SEL_XO_DIV8    6'h36
`define SOPS_SEL_XO_DIV12   6'h37
`define SOPS_SEL_XO_DIV16   6'h38
`define SOPS_SEL_XO_DIV24   6'h39
`define SOPS_SEL_XO_DIV192  6'h3f

`define SOPS_DIV_2          8'h02
`define SOPS_DIV_3          8'h03
`define SOPS_DIV_4          8'h04
`define SOPS_DIV_6          8'h06
`define SOPS_DIV_8          8'h08
`define SOPS_DIV_12         8'h0c
`define SOPS_DIV_16         8'h10
`define SOPS_DIV_24         8'h18
`define SOPS_DIV_192        8'hc0

`endif

// *** common/sops_pkg.sv ***
// types of the status output pin selector
package sops_pkg;
    typedef struct packed {
        logic       invert;
        logic [5:0] select;
    } sops_cfg_s;

    typedef struct packed {
        logic       run;
        logic [7:0] period;
        logic [7:0] high;
    } sops_div_cfg_s;

    typedef struct packed {
        logic [7:0] cnt;
        logic       clk;
    } sops_div_state_s;

    typedef struct packed {
        sops_cfg_s [2:0] cfg;
        logic [2:0]      pin_val;
        logic [2:0]      pin_oe;
        logic            f_rx_eop;
        logic            f_tx_full;
        logic            f_rx_ovf;
        logic            f_tx_unf;
        logic            f_sync;
        logic            f_crc_pkt;
        logic            f_crc_match;
        logic            cs_meta;
        logic            cs_sync;
        logic            txd_meta;
        logic            txd_sync;
        logic            tx_bit;
        logic            tx_bit_vld;
        logic            aw_held;
        logic [7:0]      aw_addr;
        logic            w_held;
        logic [6:0]      w_data;
        logic            w_be;
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [31:0]     rdata;
    } sops_top_state_s;
endpackage

// *** common/sops_div_if.sv ***
// control and output of the crystal clock divider
`timescale 1ns/1ns
interface sops_div_if;
    sops_pkg::sops_div_cfg_s cfg;
    logic                    clk_div;

    modport ctrl (output cfg, input clk_div);
    modport gen  (input cfg, output clk_div);
endinterface

// *** hw/sops_clk_div.sv ***
// crystal clock divider with programmable period and high time
`timescale 1ns/1ns
`include "sops_defines.svh"
module sops_clk_div
(
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_b_in,
    // divider control and output
    sops_div_if.gen   div
);
    sops_pkg::sops_div_state_s s_reg;
    sops_pkg::sops_div_state_s s_next;

    // a period change takes effect at once: the count wraps as soon as it reaches the new period minus one
    always_comb
    begin
        s_next = s_reg;
        if (!div.cfg.run)
        begin
            s_next.cnt = 8'h00;
        end
        else if (s_reg.cnt >= 8'(div.cfg.period - 8'h01))
        begin
            s_next.cnt = 8'h00;
        end
        else
        begin
            s_next.cnt = 8'(s_reg.cnt + 8'h01);
        end
        s_next.clk = div.cfg.run && (s_next.cnt < div.cfg.high);
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign div.clk_div = s_reg.clk;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_DIV_IDLE: assert property (!div.cfg.run |=> !div.clk_div) // [R22]
        else $error("divided clock toggles while stopped");
    AST_DIV_WRAP: assert property (
        (div.cfg.run && $past(div.cfg.run) && $stable(div.cfg.period))
        |-> (s_reg.cnt < div.cfg.period)) // [R22]
        else $error("divider count beyond period");
endmodule

// *** hw/sops_top.sv ***
// status output pin selector: three pins, each with a source select and inversion
// Function
// [R1] code 00: rx level at or above threshold
// [R2] code 01: rx threshold or packet end, until empty
// [R3] code 02: tx level at or above threshold
// [R4] code 03: tx full, until below threshold
// [R5] code 04: rx overflow, until rx flushed
// [R6] code 05: tx underflow, until tx flushed
// [R7] code 06: sync word seen, until packet end
// [R8] code 06 rx: drop or overflow also ends
// [R9] code 06 tx: underflow also ends it
// [R10] code 07: good checksum, until first read
// [R11] host avoids test codes 08, 10-1a
// [R12] code 09: signal below channel clear threshold
// [R13] code 0a: pll lock, host takes edge
// [R14] code 0b: serial clock, rx data falling
// [R15] tx data sampled on output clock rise
// [R16] code 0c: synchronous received data
// [R17] code 0d: asynchronous received data
// [R18] code 0e: carrier sense, cleared by idle
// [R19] code 0f: last checksum match, cleared rx start
// [R20] code 1b: amplifier power down line
// [R21] host routes one divided clock only
// [R22] pin zero resets to crystal divided 192
// [R23] pin one drives only while select high
// [R24] codes below 20 hold fixed in sleep
// [R25] inversion bit applied to each source
`timescale 1ns/1ns
`include "sops_defines.svh"
module sops_top
(
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_b_in,
    // axi4-lite register slave
    input  wire logic [7:0]  axi_awaddr_in,
    input  wire logic        axi_awvalid_in,
    output logic             axi_awready_out,
    input  wire logic [31:0] axi_wdata_in,
    input  wire logic [3:0]  axi_wstrb_in,
    input  wire logic        axi_wvalid_in,
    output logic             axi_wready_out,
    output logic [1:0]       axi_bresp_out,
    output logic             axi_bvalid_out,
    input  wire logic        axi_bready_in,
    input  wire logic [7:0]  axi_araddr_in,
    input  wire logic        axi_arvalid_in,
    output logic             axi_arready_out,
    output logic [31:0]      axi_rdata_out,
    output logic [1:0]       axi_rresp_out,
    output logic             axi_rvalid_out,
    input  wire logic        axi_rready_in,
    // buffer status from the radio core
    input  wire logic        rx_fifo_at_thr_in,
    input  wire logic        rx_fifo_empty_in,
    input  wire logic        rx_end_pkt_in,
    input  wire logic        tx_fifo_at_thr_in,
    input  wire logic        tx_fifo_full_in,
    input  wire logic        rx_overflow_in,
    input  wire logic        rx_fifo_flush_in,
    input  wire logic        tx_underflow_in,
    input  wire logic        tx_fifo_flush_in,
    // packet events from the radio core
    input  wire logic        sync_word_in,
    input  wire logic        pkt_drop_in,
    input  wire logic        crc_pkt_ok_in,
    input  wire logic        rx_first_read_in,
    input  wire logic        crc_cmp_done_in,
    input  wire logic        crc_match_in,
    input  wire logic        rx_start_in,
    // radio levels
    input  wire logic        cca_clear_in,
    input  wire logic        pll_lock_in,
    input  wire logic        serial_clk_in,
    input  wire logic        rx_sync_data_in,
    input  wire logic        rx_async_data_in,
    input  wire logic        carrier_in,
    input  wire logic        radio_idle_in,
    input  wire logic        amp_power_down_in,
    input  wire logic        sleep_in,
    // pins from the host
    input  wire logic        chip_select_n_in,
    input  wire logic        serial_tx_data_in,
    // output pins
    output logic             gen_out_0_out,
    output logic             gen_out_0_oe_out,
    output logic             gen_out_1_out,
    output logic             gen_out_1_oe_out,
    output logic             gen_out_2_out,
    output logic             gen_out_2_oe_out,
    // sampled serial transmit data
    output logic             tx_sample_out,
    output logic             tx_sample_vld_out
);
    localparam sops_pkg::sops_top_state_s RST_STATE = '{
        cfg:     {`SOPS_RST_CFG2, `SOPS_RST_CFG1, `SOPS_RST_CFG0}, // [R22] [R23]
        default: '0
    };

    sops_pkg::sops_top_state_s s_reg;
    sops_pkg::sops_top_state_s s_next;
    sops_pkg::sops_div_cfg_s   div_cfg;
    wire [2:0]                 pin_nxt;
    wire [2:0]                 pin_oe_nxt;

    sops_div_if div_if ();

    sops_clk_div u_clk_div
    (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .div        (div_if.gen)
    );

    function automatic logic [7:0] xo_period(input logic [5:0] sel);
        logic [7:0] p;
        case (sel)
            // a flip-flop clock cannot reach /1 or /1.5, so both fall back to /2
            `SOPS_SEL_XO_DIV1:   p = `SOPS_DIV_2;
            `SOPS_SEL_XO_DIV1P5: p = `SOPS_DIV_2;
            `SOPS_SEL_XO_DIV2:   p = `SOPS_DIV_2;
            `SOPS_SEL_XO_DIV3:   p = `SOPS_DIV_3;
            `SOPS_SEL_XO_DIV4:   p = `SOPS_DIV_4;
            `SOPS_SEL_XO_DIV6:   p = `SOPS_DIV_6;
            `SOPS_SEL_XO_DIV8:   p = `SOPS_DIV_8;
            `SOPS_SEL_XO_DIV12:  p = `SOPS_DIV_12;
            `SOPS_SEL_XO_DIV16:  p = `SOPS_DIV_16;
            `SOPS_SEL_XO_DIV24:  p = `SOPS_DIV_24;
            default:             p = `SOPS_DIV_192;
        endcase
        return p;
    endfunction

    // one shared divider; if the host breaks the one-clock limit, lowest pin wins
    always_comb
    begin
        div_cfg = '0;
        for (int k = 2; k >= 0; k--)
        begin
            if (s_reg.cfg[k].select >= `SOPS_SEL_XO_MIN)
            begin
                div_cfg.run    = 1'b1;
                div_cfg.period = xo_period(s_reg.cfg[k].select); // [R21]
            end
        end
        div_cfg.high = div_cfg.period >> 1;
    end

    assign div_if.cfg = div_cfg;

    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_pin
            logic src;
            logic nxt;
            logic oe;

            always_comb
            begin
                case (s_reg.cfg[i].select)
                    `SOPS_SEL_RX_THR:    src = rx_fifo_at_thr_in;        // [R1]
                    `SOPS_SEL_RX_EOP:    src = s_reg.f_rx_eop;           // [R2]
                    `SOPS_SEL_TX_THR:    src = tx_fifo_at_thr_in;        // [R3]
                    `SOPS_SEL_TX_FULL:   src = s_reg.f_tx_full;          // [R4]
                    `SOPS_SEL_RX_OVF:    src = s_reg.f_rx_ovf;           // [R5]
                    `SOPS_SEL_TX_UNF:    src = s_reg.f_tx_unf;           // [R6]
                    `SOPS_SEL_SYNC:      src = s_reg.f_sync;             // [R7]
                    `SOPS_SEL_CRC_PKT:   src = s_reg.f_crc_pkt;          // [R10]
                    `SOPS_SEL_CCA:       src = cca_clear_in;             // [R12]
                    `SOPS_SEL_PLL:       src = pll_lock_in;              // [R13]
                    `SOPS_SEL_SER_CLK:   src = serial_clk_in;            // [R14]
                    `SOPS_SEL_SER_SDATA: src = rx_sync_data_in;          // [R16]
                    `SOPS_SEL_SER_ADATA: src = rx_async_data_in;         // [R17]
                    `SOPS_SEL_CARRIER:   src = carrier_in && !radio_idle_in; // [R18]
                    `SOPS_SEL_CRC_MATCH: src = s_reg.f_crc_match;        // [R19]
                    `SOPS_SEL_AMP_PD:    src = amp_power_down_in;        // [R20]
                    `SOPS_SEL_HIZ:       src = 1'b0;
                    `SOPS_SEL_ZERO:      src = 1'b0;
                    default:
                    begin
                        // test codes and unsupported codes read as low
                        if (s_reg.cfg[i].select >= `SOPS_SEL_XO_MIN)
                            src = div_if.clk_div; // [R22]
                        else
                            src = 1'b0;
                    end
                endcase
                // pin one idles high in sleep, the others low, before inversion
                if (sleep_in && (s_reg.cfg[i].select < `SOPS_SEL_SLEEP_LIM))
                    nxt = (i == 1) ? ~s_reg.cfg[i].invert : s_reg.cfg[i].invert; // [R24]
                else
                    nxt = src ^ s_reg.cfg[i].invert; // [R25]
                oe = (s_reg.cfg[i].select != `SOPS_SEL_HIZ) && ((i != 1) || s_reg.cs_sync); // [R23]
            end

            assign pin_nxt[i]    = nxt;
            assign pin_oe_nxt[i] = oe;
        end
    endgenerate

    always_comb
    begin
        s_next = s_reg;

        s_next.pin_val = pin_nxt;
        s_next.pin_oe  = pin_oe_nxt;

        // set wins over clear on every sticky flag
        s_next.f_rx_eop  = rx_fifo_at_thr_in || rx_end_pkt_in
                           || (s_reg.f_rx_eop && !rx_fifo_empty_in);              // [R2]
        s_next.f_tx_full = tx_fifo_full_in || (s_reg.f_tx_full && tx_fifo_at_thr_in); // [R4]
        s_next.f_rx_ovf  = rx_overflow_in || (s_reg.f_rx_ovf && !rx_fifo_flush_in);   // [R5]
        s_next.f_tx_unf  = tx_underflow_in || (s_reg.f_tx_unf && !tx_fifo_flush_in);  // [R6]
        s_next.f_sync    = sync_word_in
                           || (s_reg.f_sync && !rx_end_pkt_in && !pkt_drop_in     // [R7] [R8]
                               && !rx_overflow_in && !tx_underflow_in);           // [R9]
        s_next.f_crc_pkt = crc_pkt_ok_in || (s_reg.f_crc_pkt && !rx_first_read_in);   // [R10]
        if (crc_cmp_done_in)
            s_next.f_crc_match = crc_match_in; // [R19]
        else if (rx_start_in)
            s_next.f_crc_match = 1'b0; // [R19]

        // host pins pass two flip-flops before use
        s_next.cs_meta  = chip_select_n_in;
        s_next.cs_sync  = s_reg.cs_meta;
        s_next.txd_meta = serial_tx_data_in;
        s_next.txd_sync = s_reg.txd_meta;

        // transmit data is taken as the serial clock pin rises
        s_next.tx_bit_vld = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            if ((s_reg.cfg[k].select == `SOPS_SEL_SER_CLK) && pin_nxt[k] && !s_reg.pin_val[k])
            begin
                s_next.tx_bit     = s_reg.txd_sync; // [R15]
                s_next.tx_bit_vld = 1'b1;
            end
        end

        // write channel: address and data taken in either order
        if (axi_awvalid_in && s_reg.awready)
        begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = axi_awaddr_in;
        end
        if (axi_wvalid_in && s_reg.wready)
        begin
            s_next.w_held = 1'b1;
            s_next.w_data = axi_wdata_in[`SOPS_CFG_INV_BIT:0];
            s_next.w_be   = axi_wstrb_in[0];
        end
        if (s_reg.bvalid && axi_bready_in)
            s_next.bvalid = 1'b0;
        if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid)
        begin
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = (s_reg.aw_addr == `SOPS_OFF_STATUS) ? `SOPS_RESP_OKAY
                                                                 : `SOPS_RESP_DECERR;
            for (int k = 0; k < 3; k++)
            begin
                if (s_reg.aw_addr == 8'(`SOPS_OFF_CFG0 + k * `SOPS_REG_STRIDE))
                begin
                    s_next.bresp = `SOPS_RESP_OKAY;
                    if (s_reg.w_be)
                    begin
                        s_next.cfg[k].invert = s_reg.w_data[`SOPS_CFG_INV_BIT];
                        s_next.cfg[k].select = s_reg.w_data[`SOPS_CFG_SEL_MSB:0];
                    end
                end
            end
        end
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready  = !s_next.w_held && !s_next.bvalid;

        // read channel: answer one cycle after the address is taken
        if (s_reg.rvalid && axi_rready_in)
            s_next.rvalid = 1'b0;
        if (axi_arvalid_in && s_reg.arready)
        begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = `SOPS_RESP_DECERR;
            s_next.rdata  = 32'h0000_0000;
            if (axi_araddr_in == `SOPS_OFF_STATUS)
            begin
                s_next.rresp = `SOPS_RESP_OKAY;
                s_next.rdata = 32'({s_reg.f_crc_match, s_reg.f_crc_pkt, s_reg.f_sync,
                                    s_reg.f_tx_unf, s_reg.f_rx_ovf, s_reg.f_tx_full,
                                    s_reg.f_rx_eop, s_reg.pin_oe, s_reg.pin_val});
            end
            for (int k = 0; k < 3; k++)
            begin
                if (axi_araddr_in == 8'(`SOPS_OFF_CFG0 + k * `SOPS_REG_STRIDE))
                begin
                    s_next.rresp = `SOPS_RESP_OKAY;
                    s_next.rdata = 32'(s_reg.cfg[k]);
                end
            end
        end
        s_next.arready = !s_next.rvalid;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            s_reg <= RST_STATE;
        else
            s_reg <= s_next;
    end

    assign axi_awready_out   = s_reg.awready;
    assign axi_wready_out    = s_reg.wready;
    assign axi_bvalid_out    = s_reg.bvalid;
    assign axi_bresp_out     = s_reg.bresp;
    assign axi_arready_out   = s_reg.arready;
    assign axi_rvalid_out    = s_reg.rvalid;
    assign axi_rresp_out     = s_reg.rresp;
    assign axi_rdata_out     = s_reg.rdata;
    assign gen_out_0_out     = s_reg.pin_val[0];
    assign gen_out_1_out     = s_reg.pin_val[1];
    assign gen_out_2_out     = s_reg.pin_val[2];
    assign gen_out_0_oe_out  = s_reg.pin_oe[0];
    assign gen_out_1_oe_out  = s_reg.pin_oe[1];
    assign gen_out_2_oe_out  = s_reg.pin_oe[2];
    assign tx_sample_out     = s_reg.tx_bit;
    assign tx_sample_vld_out = s_reg.tx_bit_vld;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_RX_THR_PIN: assert property (
        (s_reg.cfg[2].select == `SOPS_SEL_RX_THR && !sleep_in)
        |=> gen_out_2_out == ($past(rx_fifo_at_thr_in) ^ $past(s_reg.cfg[2].invert))) // [R1]
        else $error("pin 2 does not follow rx threshold");
    AST_RX_EOP_HOLD: assert property (
        (rx_end_pkt_in ##1 !rx_fifo_empty_in) |=> s_reg.f_rx_eop) // [R2]
        else $error("rx end flag dropped before empty");
    AST_TX_FULL_HOLD: assert property (
        (s_reg.f_tx_full && tx_fifo_at_thr_in) |=> s_reg.f_tx_full) // [R4]
        else $error("tx full flag dropped above threshold");
    AST_RX_OVF_FLUSH: assert property (
        (rx_overflow_in ##1 (!rx_fifo_flush_in)[*2]) |=> s_reg.f_rx_ovf) // [R5]
        else $error("overflow flag lost before flush");
    AST_SYNC_DROP: assert property (
        (s_reg.f_sync && (pkt_drop_in || rx_overflow_in) && !sync_word_in)
        |=> !s_reg.f_sync) // [R8]
        else $error("sync flag survives a drop");
    AST_SYNC_UNF: assert property (
        (tx_underflow_in && !sync_word_in) |=> (!s_reg.f_sync && s_reg.f_tx_unf)) // [R9]
        else $error("underflow did not end sync flag");
    AST_CRC_PKT: assert property (
        crc_pkt_ok_in |=> s_reg.f_crc_pkt) // [R10]
        else $error("good packet flag not set");
    AST_CRC_MATCH_CLR: assert property (
        (rx_start_in && !crc_cmp_done_in) |=> !s_reg.f_crc_match) // [R19]
        else $error("checksum match survives rx start");
    AST_SLEEP_FORCE: assert property (
        (sleep_in && s_reg.cfg[2].select < `SOPS_SEL_SLEEP_LIM)
        |=> gen_out_2_out == $past(s_reg.cfg[2].invert)) // [R24]
        else $error("pin 2 not held in sleep");
    AST_PIN1_HIZ: assert property (
        !s_reg.cs_sync |=> !gen_out_1_oe_out) // [R23]
        else $error("pin 1 driven while selected");
    AST_PLL_INV: assert property (
        (s_reg.cfg[2].select == `SOPS_SEL_PLL && !sleep_in)
        |=> gen_out_2_out == ($past(pll_lock_in) ^ $past(s_reg.cfg[2].invert))) // [R25]
        else $error("pin 2 inversion wrong");
    AST_DIV192: assert property (
        (s_reg.cfg[0].select == `SOPS_SEL_XO_DIV192) |-> div_cfg.period == `SOPS_DIV_192) // [R22]
        else $error("pin 0 divider period wrong");

    COV_SYNC: cover property (s_reg.f_sync ##1 !s_reg.f_sync);
    COV_OVF_FLUSH: cover property (s_reg.f_rx_ovf ##1 rx_fifo_flush_in ##1 !s_reg.f_rx_ovf);
    COV_SLEEP: cover property (sleep_in && s_reg.cfg[0].select < `SOPS_SEL_SLEEP_LIM);
    COV_DIVCLK: cover property (!gen_out_0_out ##1 gen_out_0_out);
endmodule

// *** bench/sops_host_model.sv ***
// host side: chip select and serial transmit data
`timescale 1ns/1ns
module sops_host_model
(
    // serial clock from the device, select request from the bench
    input  wire logic ser_clk_in,
    input  wire logic sel_in,
    // pins to the device
    output logic      chip_select_n_out,
    output logic      tx_data_out
);
    assign chip_select_n_out = ~sel_in;
    initial tx_data_out = 1'h0;
    // data moves on the falling edge so it is steady at the sampling rise
    always @(negedge ser_clk_in) tx_data_out <= ~tx_data_out;
endmodule

// *** bench/sops_top_tb.sv ***
// self-checking bench of the status output pin selector
`timescale 1ns/1ns
module sops_top_tb;
    logic ref_clk_in = 1'h0, rst_b_in = 1'h0, sel = 1'h0;
    logic axi_awvalid_in = 1'h0, axi_wvalid_in = 1'h0, axi_bready_in = 1'h0;
    logic axi_arvalid_in = 1'h0, axi_rready_in = 1'h0;
    logic [7:0] axi_awaddr_in = 8'h0, axi_araddr_in = 8'h0;
    logic [31:0] axi_wdata_in = 32'h0, axi_rdata_out, r;
    logic [3:0] axi_wstrb_in = 4'hf;
    logic [24:0] s = 25'h0;
    logic [1:0] axi_bresp_out, axi_rresp_out;
    logic axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out, axi_rvalid_out;
    logic gen_out_0_out, gen_out_0_oe_out, gen_out_1_out, gen_out_1_oe_out, gen_out_2_out;
    logic gen_out_2_oe_out, tx_sample_out, tx_sample_vld_out, chip_select_n_in;
    logic serial_tx_data_in;
    logic [65:0] q[$];
    logic [65:0] nt;
    logic [6:0] pv;
    logic [5:0] lc[8] = '{6'h00, 6'h02, 6'h09, 6'h0a, 6'h0c, 6'h0d, 6'h0e, 6'h1b};
    logic [17:0] st[9] = '{{6'h04, 6'h0d, 6'h0e}, {6'h05, 6'h0f, 6'h10}, {6'h06, 6'h11, 6'h12},
        {6'h06, 6'h11, 6'h15}, {6'h06, 6'h11, 6'h0d}, {6'h06, 6'h11, 6'h0f},
        {6'h07, 6'h13, 6'h14}, {6'h01, 6'h12, 6'h0b}, {6'h0f, 6'h17, 6'h18}};
    int mismatches = 0, cmp_count = 0, seed = 32'h6dd0, k;
    time t;
    sops_top dut_u (.rx_fifo_at_thr_in(s[0]), .tx_fifo_at_thr_in(s[1]), .cca_clear_in(s[2]),
        .pll_lock_in(s[3]), .rx_sync_data_in(s[4]), .rx_async_data_in(s[5]), .carrier_in(s[6]),
        .amp_power_down_in(s[7]), .serial_clk_in(s[8]), .radio_idle_in(s[9]), .sleep_in(s[10]),
        .rx_fifo_empty_in(s[11]), .crc_match_in(s[12]), .rx_overflow_in(s[13]),
        .rx_fifo_flush_in(s[14]), .tx_underflow_in(s[15]), .tx_fifo_flush_in(s[16]),
        .sync_word_in(s[17]), .rx_end_pkt_in(s[18]), .crc_pkt_ok_in(s[19]),
        .rx_first_read_in(s[20]), .pkt_drop_in(s[21]), .tx_fifo_full_in(s[22]),
        .crc_cmp_done_in(s[23]), .rx_start_in(s[24]), .*);
    sops_host_model host_u (.ser_clk_in(gen_out_0_out), .sel_in(sel),
        .chip_select_n_out(chip_select_n_in), .tx_data_out(serial_tx_data_in));
    initial forever #50 ref_clk_in = ~ref_clk_in;
    task check(input string n, input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        {axi_awaddr_in, axi_wdata_in} <= {a, d};
        {axi_awvalid_in, axi_wvalid_in, axi_bready_in} <= 3'h7;
        forever
        begin
            @(posedge ref_clk_in);
            if (axi_awready_out) axi_awvalid_in <= 1'h0;
            if (axi_wready_out) axi_wvalid_in <= 1'h0;
            if (axi_bvalid_out) break;
        end
        axi_bready_in <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [1:0] rs, input logic [31:0] m, input logic [31:0] e);
        q.push_back({rs, m, e});
        @(posedge ref_clk_in);
        axi_araddr_in <= a;
        {axi_arvalid_in, axi_rready_in} <= 2'h3;
        forever
        begin
            @(posedge ref_clk_in);
            if (axi_arready_out) axi_arvalid_in <= 1'h0;
            if (axi_rvalid_out) break;
        end
        axi_rready_in <= 1'h0;
    endtask
    // pin levels are read back through the status word
    task chk(input logic [31:0] m, input logic [31:0] e);
        repeat (3) @(posedge ref_clk_in);
        pv = {gen_out_2_oe_out, gen_out_0_oe_out, gen_out_1_oe_out, 1'h0, gen_out_2_out,
              gen_out_1_out, 1'h0};
        check("pin", 34'(pv & {2'h3, m[4:0]}), 34'({2'h3, e[4:0]}));
        rd(8'h0c, 2'h0, m, e);
    endtask
    task pulse(input int b);
        @(posedge ref_clk_in);
        s[b] <= 1'h1;
        @(posedge ref_clk_in);
        s[b] <= 1'h0;
    endtask
    always @(posedge ref_clk_in)
    begin
        if (axi_rvalid_out && axi_rready_in)
        begin
            nt = q.pop_front();
            check("rd", {axi_rresp_out, axi_rdata_out & nt[63:32]}, {nt[65:64], nt[31:0]});
        end
        if (tx_sample_vld_out)
            check("tx", {33'h0, tx_sample_out}, {33'h0, serial_tx_data_in});
        if (axi_bvalid_out && axi_bready_in)
            check("wr", {32'h0, axi_bresp_out}, 34'h0);
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk_in);
        mismatches++;
        tally_and_finish;
    end
    initial
    begin
        repeat (2) @(posedge ref_clk_in);
        rst_b_in <= 1'h1;
        rd(8'h00, 2'h0, 32'h7f, 32'h3f);
        rd(8'h04, 2'h0, 32'h7f, 32'h2e);
        rd(8'h08, 2'h0, 32'h7f, 32'h2f);
        rd(8'h10, 2'h3, 32'hffff_ffff, 32'h0);
        @(posedge gen_out_0_out);
        t = $time;
        @(posedge gen_out_0_out);
        check("div", 34'(($time - t) / 100), 34'h0c0);
        // test codes and a second divided clock are never programmed
        for (k = 0; k < 16; k++)
        begin
            r = $random(seed);
            wr(8'h08, {25'h0, r[1], lc[k % 8]});
            s[k % 8] <= r[0];
            chk(32'h4, {29'h0, r[0] ^ r[1], 2'h0});
        end
        s[9] <= 1'h1;
        chk(32'h4, {29'h0, r[0] ^ r[1], 2'h0});
        wr(8'h08, 32'h0e);
        s[6] <= 1'h1;
        chk(32'h4, 32'h0);
        {s[12], s[9], s[7:0]} <= 10'h200;
        for (k = 0; k < 9; k++)
        begin
            wr(8'h08, {26'h0, st[k][17:12]});
            pulse(st[k][11:6]);
            chk(32'h4, 32'h4);
            pulse(st[k][5:0]);
            chk(32'h4, 32'h0);
        end
        s[1] <= 1'h1;
        wr(8'h08, 32'h03);
        pulse(22);
        chk(32'h4, 32'h4);
        s[1] <= 1'h0;
        chk(32'h4, 32'h0);
        {s[10], s[2]} <= 2'h3;
        wr(8'h08, 32'h09);
        chk(32'h4, 32'h0);
        s[10] <= 1'h0;
        for (k = 0; k < 2; k++)
        begin
            sel <= k[0];
            wr(8'h04, 32'h0a);
            chk(32'h12, {27'h0, ~k[0], 2'h0, s[3], 1'h0});
        end
        wr(8'h00, 32'h0b);
        repeat (40)
        begin
            repeat (4) @(posedge ref_clk_in);
            s[8] <= ~s[8];
        end
        tally_and_finish;
    end
endmodule
